//--- design/dspt_bank.sv
/*
 * Descriptor shadow registers and transmit/receive poll timers.
 * Assumes the descriptor fetch logic presents word 1 of each descriptor
 * with a one-cycle load strobe, and a Wishbone classic master for software.
 */
// The implementer's own choices: the placing of the registers and register access over Wishbone.
`timescale 1ns/1ps

module dspt_bank
  import dspt_pkg::*;
#(
  parameter int ADDR_W = 6,
  parameter int INIT_CYCLES = DSPT_INIT_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire dspt_desc_s cur_rx_desc_i,
  input wire dspt_desc_s cur_tx_desc_i,
  input wire dspt_desc_s nxt_rx_desc_i,
  input wire logic soft_reset_i,
  output logic tx_poll_o,
  output logic rx_poll_o,
  output logic running_o
);

  initial begin
    if (ADDR_W < 6 || ADDR_W > 16) begin
      $error("ADDR_W must lie between 6 and 16");
    end
    if (INIT_CYCLES < 1 || INIT_CYCLES > 255) begin
      $error("INIT_CYCLES must lie between 1 and 255");
    end
  end

  logic [15:0] bank_q [DSPT_NUM_BANK];
  logic stop_q;
  logic suspend_q;
  logic run_q;
  logic idone_q;
  dspt_init_e init_q;
  logic [7:0] init_cnt_q;
  logic ack_q;
  logic err_q;
  logic [31:0] rdat_q;
  logic tx_poll_q;
  logic rx_poll_q;

  logic req;
  logic [3:0] idx;
  logic mapped;
  logic is_bank;
  logic bank_open;
  logic wr_bank;
  logic wr_ctrl;
  logic counting;
  logic init_end;
  logic [15:0] wmerge;
  logic [15:0] tx_reload;
  logic [15:0] rx_reload;

  function automatic logic [15:0] field_mask(input logic [3:0] i);
    case (i)
      DSPT_IDX_CUR_RX_BC, DSPT_IDX_CUR_TX_BC, DSPT_IDX_NXT_RX_BC: field_mask = DSPT_BC_MASK;
      default: field_mask = DSPT_FULL_MASK;
    endcase
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_q & ~err_q;
  assign idx = wb_adr_i[5:2];
  assign mapped = (wb_adr_i[ADDR_W-1:2] <= (ADDR_W-2)'(DSPT_IDX_STATUS)) &&
      (wb_adr_i[1:0] == 2'h0);
  assign is_bank = idx < DSPT_IDX_CTRL;
  // Software access only while the sequencer is parked
  assign bank_open = stop_q | suspend_q;
  assign wr_bank = req & wb_we_i & mapped & is_bank & bank_open;
  assign wr_ctrl = req & wb_we_i & mapped & (idx == DSPT_IDX_CTRL);
  assign counting = run_q & ~stop_q & ~suspend_q;
  assign init_end = (init_q == DSPT_INIT) && (init_cnt_q == 8'(INIT_CYCLES - 1));

  // Low two byte lanes only; upper half is reserved
  always_comb begin
    wmerge = bank_q[idx < DSPT_IDX_CTRL ? idx : 4'h0];
    if (wb_sel_i[0]) begin
      wmerge[7:0] = wb_dat_i[7:0];
    end
    if (wb_sel_i[1]) begin
      wmerge[15:8] = wb_dat_i[15:8];
    end
  end

  // Low nibble of the interval is ignored
  assign tx_reload = bank_q[DSPT_IDX_TX_PINT] & DSPT_PINT_MASK;
  assign rx_reload = bank_q[DSPT_IDX_RX_PINT] & DSPT_PINT_MASK;

  // No reset on purpose: contents survive hardware and software reset
  always_ff @(posedge clk_i) begin
    if (wr_bank) begin
      bank_q[idx] <= wmerge & field_mask(idx);
    end
    // Hardware captures win over a coincident software write
    if (cur_rx_desc_i.load) begin
      bank_q[DSPT_IDX_CUR_RX_BC] <= {4'h0, cur_rx_desc_i.word1[DSPT_BC_MSB:0]};
      bank_q[DSPT_IDX_CUR_RX_ST] <= cur_rx_desc_i.word1[31:DSPT_ST_LSB];
    end
    if (cur_tx_desc_i.load) begin
      bank_q[DSPT_IDX_CUR_TX_BC] <= {4'h0, cur_tx_desc_i.word1[DSPT_BC_MSB:0]};
      bank_q[DSPT_IDX_CUR_TX_ST] <= cur_tx_desc_i.word1[31:DSPT_ST_LSB];
    end
    if (nxt_rx_desc_i.load) begin
      bank_q[DSPT_IDX_NXT_RX_BC] <= {4'h0, nxt_rx_desc_i.word1[DSPT_BC_MSB:0]};
      bank_q[DSPT_IDX_NXT_RX_ST] <= nxt_rx_desc_i.word1[31:DSPT_ST_LSB];
    end
    if (counting) begin
      if (bank_q[DSPT_IDX_TX_POLL] == DSPT_CNT_WRAP) begin
        bank_q[DSPT_IDX_TX_POLL] <= tx_reload;
      end else begin
        bank_q[DSPT_IDX_TX_POLL] <= bank_q[DSPT_IDX_TX_POLL] + 16'h0001;
      end
      if (bank_q[DSPT_IDX_RX_POLL] == DSPT_CNT_WRAP) begin
        bank_q[DSPT_IDX_RX_POLL] <= rx_reload;
      end else begin
        bank_q[DSPT_IDX_RX_POLL] <= bank_q[DSPT_IDX_RX_POLL] + 16'h0001;
      end
    end
    // Zero interval comes from the init routine, never from reset
    if (init_end) begin
      bank_q[DSPT_IDX_TX_PINT] <= DSPT_PINT_INIT;
      bank_q[DSPT_IDX_RX_PINT] <= DSPT_PINT_INIT;
      bank_q[DSPT_IDX_TX_POLL] <= DSPT_PINT_INIT;
      bank_q[DSPT_IDX_RX_POLL] <= DSPT_PINT_INIT;
    end
  end

  // Poll strobes; gated by run so unknown counters never leak out
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tx_poll_q <= 1'b0;
      rx_poll_q <= 1'b0;
    end else begin
      tx_poll_q <= counting && (bank_q[DSPT_IDX_TX_POLL] == DSPT_CNT_WRAP);
      rx_poll_q <= counting && (bank_q[DSPT_IDX_RX_POLL] == DSPT_CNT_WRAP);
    end
  end

  // Run, stop and suspend control
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      stop_q <= DSPT_STOP_RST;
      run_q <= DSPT_RUN_RST;
      suspend_q <= 1'b0;
    end else if (soft_reset_i) begin
      stop_q <= 1'b1;
      run_q <= 1'b0;
      suspend_q <= 1'b0;
    end else if (wr_ctrl && wb_sel_i[0]) begin
      suspend_q <= wb_dat_i[DSPT_CTRL_SUSPEND];
      if (wb_dat_i[DSPT_CTRL_STOP]) begin
        stop_q <= 1'b1;
        run_q <= 1'b0;
      end else if (wb_dat_i[DSPT_CTRL_START]) begin
        stop_q <= 1'b0;
        run_q <= 1'b1;
      end else if (wb_dat_i[DSPT_CTRL_INIT]) begin
        stop_q <= 1'b0;
      end
    end
  end

  // Internal initialization routine
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      init_q <= DSPT_IDLE;
      init_cnt_q <= 8'h00;
    end else begin
      case (init_q)
        DSPT_IDLE, DSPT_DONE: begin
          init_cnt_q <= 8'h00;
          if (wr_ctrl && wb_sel_i[0] && wb_dat_i[DSPT_CTRL_INIT] && !wb_dat_i[DSPT_CTRL_STOP]) begin
            init_q <= DSPT_INIT;
          end
        end
        DSPT_INIT: begin
          init_cnt_q <= init_cnt_q + 8'h01;
          if (init_end) begin
            init_q <= DSPT_DONE;
          end
        end
        default: init_q <= DSPT_IDLE;
      endcase
    end
  end

  // Completion flag; completion wins over a clearing init write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      idone_q <= 1'b0;
    end else if (init_end) begin
      idone_q <= 1'b1;
    end else if (wr_ctrl && wb_sel_i[0] && wb_dat_i[DSPT_CTRL_INIT]) begin
      idone_q <= 1'b0;
    end
  end

  // Wishbone answer one cycle after the request; unmapped gets err
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      err_q <= 1'b0;
      rdat_q <= 32'h00000000;
    end else begin
      ack_q <= req & mapped;
      err_q <= req & ~mapped;
      rdat_q <= 32'h00000000;
      if (req && mapped && !wb_we_i) begin
        if (is_bank && bank_open) begin
          rdat_q <= {16'h0000, bank_q[idx] & field_mask(idx)};
        end else if (idx == DSPT_IDX_CTRL) begin
          rdat_q[DSPT_CTRL_STOP] <= stop_q;
          rdat_q[DSPT_CTRL_SUSPEND] <= suspend_q;
          rdat_q[DSPT_CTRL_START] <= run_q;
        end else if (idx == DSPT_IDX_STATUS) begin
          rdat_q[DSPT_STAT_IDONE] <= idone_q;
          rdat_q[DSPT_STAT_RUN] <= counting;
          rdat_q[DSPT_STAT_IBUSY] <= (init_q == DSPT_INIT);
        end
      end
    end
  end

  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;
  assign wb_err_o = err_q;
  assign tx_poll_o = tx_poll_q;
  assign rx_poll_o = rx_poll_q;
  assign running_o = counting;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Init end overrides the reload, so wraps in that cycle are left out
  sequence s_tx_wrap;
    counting && !init_end && (bank_q[DSPT_IDX_TX_POLL] == DSPT_CNT_WRAP);
  endsequence

  sequence s_rx_wrap;
    counting && !init_end && (bank_q[DSPT_IDX_RX_POLL] == DSPT_CNT_WRAP);
  endsequence

  a_tx_poll_wrap: assert property (s_tx_wrap |=> tx_poll_o &&
      bank_q[DSPT_IDX_TX_POLL] == $past(tx_reload))
    else $error("tx poll not raised or counter not reloaded at wrap");

  a_rx_poll_wrap: assert property (s_rx_wrap |=> rx_poll_o &&
      bank_q[DSPT_IDX_RX_POLL] == $past(rx_reload))
    else $error("rx poll not raised or counter not reloaded at wrap");

  a_rx_count_step: assert property (counting && !init_end &&
      bank_q[DSPT_IDX_RX_POLL] != DSPT_CNT_WRAP
      |=> bank_q[DSPT_IDX_RX_POLL] == $past(bank_q[DSPT_IDX_RX_POLL]) + 16'h0001)
    else $error("rx poll counter did not step by one");

  a_zero_period: assert property (rx_poll_o && rx_reload == 16'h0000 &&
      counting ##1 counting [*8] |-> bank_q[DSPT_IDX_RX_POLL] == 16'h0008)
    else $error("zero interval does not restart counting from zero");

  a_cur_rx_copy: assert property (cur_rx_desc_i.load |=>
      bank_q[DSPT_IDX_CUR_RX_BC] == {4'h0, $past(cur_rx_desc_i.word1[11:0])} &&
      bank_q[DSPT_IDX_CUR_RX_ST] == $past(cur_rx_desc_i.word1[31:16]))
    else $error("current receive copy mismatch");

  a_tx_copy: assert property (cur_tx_desc_i.load |=>
      bank_q[DSPT_IDX_CUR_TX_BC] == {4'h0, $past(cur_tx_desc_i.word1[11:0])} &&
      bank_q[DSPT_IDX_CUR_TX_ST] == $past(cur_tx_desc_i.word1[31:16]))
    else $error("current transmit copy mismatch");

  a_nxt_rx_copy: assert property (nxt_rx_desc_i.load |=>
      bank_q[DSPT_IDX_NXT_RX_BC][15:12] == 4'h0 &&
      bank_q[DSPT_IDX_NXT_RX_ST] == $past(nxt_rx_desc_i.word1[31:16]))
    else $error("next receive copy mismatch");

  a_read_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("reserved upper half read non-zero");

  a_closed_write: assert property (req && wb_we_i && is_bank && !bank_open &&
      !init_end && idx == DSPT_IDX_TX_PINT
      |=> $stable(bank_q[DSPT_IDX_TX_PINT]))
    else $error("bank written while running");

  a_init_zeroes: assert property ((init_q == DSPT_INIT) ##1 (init_q == DSPT_DONE) |->
      bank_q[DSPT_IDX_TX_PINT] == 16'h0000 && bank_q[DSPT_IDX_RX_PINT] == 16'h0000 && idone_q)
    else $error("init routine did not clear poll intervals");

  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  // Poll timer behaviour
  a_tx_count_step: assert property (counting && !init_end &&
      bank_q[DSPT_IDX_TX_POLL] != DSPT_CNT_WRAP
      |=> bank_q[DSPT_IDX_TX_POLL] == $past(bank_q[DSPT_IDX_TX_POLL]) + 16'h0001)
    else $error("tx poll counter did not step by one");

  // Reload keeps the low nibble clear, so a pulse can never repeat at once
  a_tx_poll_pulse: assert property (tx_poll_o |=> !tx_poll_o)
    else $error("tx poll pulse longer than one cycle");

  a_rx_poll_pulse: assert property (rx_poll_o |=> !rx_poll_o)
    else $error("rx poll pulse longer than one cycle");

  a_tx_reload_mask: assert property (s_tx_wrap |=> bank_q[DSPT_IDX_TX_POLL][3:0] == 4'h0)
    else $error("tx reload kept low interval bits");

  a_rx_reload_mask: assert property (s_rx_wrap |=> bank_q[DSPT_IDX_RX_POLL][3:0] == 4'h0)
    else $error("rx reload kept low interval bits");

  a_poll_needs_run: assert property ((tx_poll_o || rx_poll_o) |-> $past(counting))
    else $error("poll strobe raised while not running");

  a_init_zero_cnt: assert property (init_end |=>
      bank_q[DSPT_IDX_TX_POLL] == 16'h0000 && bank_q[DSPT_IDX_RX_POLL] == 16'h0000)
    else $error("init routine did not clear poll counters");

  // Register bus behaviour
  a_req_answered: assert property (req && mapped |=> wb_ack_o && !wb_err_o)
    else $error("mapped request not acknowledged next cycle");

  a_closed_read: assert property (req && !wb_we_i && mapped && is_bank && !bank_open
      |=> wb_ack_o && wb_dat_o == 32'h00000000)
    else $error("closed bank read returned data");

  a_open_write: assert property (wr_bank && idx == DSPT_IDX_TX_PINT && !init_end
      |=> bank_q[DSPT_IDX_TX_PINT] == $past(wmerge))
    else $error("open bank write to tx interval lost");

  a_bc_read_clear: assert property (req && !wb_we_i && mapped && is_bank &&
      field_mask(idx) == DSPT_BC_MASK |=> wb_dat_o[15:12] == 4'h0)
    else $error("byte count reserved bits read non-zero");

  // Descriptor copies and retention
  a_nxt_rx_count: assert property (nxt_rx_desc_i.load |=>
      bank_q[DSPT_IDX_NXT_RX_BC] == {4'h0, $past(nxt_rx_desc_i.word1[11:0])})
    else $error("next receive byte count copy mismatch");

  a_soft_keeps: assert property (soft_reset_i && !cur_rx_desc_i.load && !wr_bank
      |=> $stable(bank_q[DSPT_IDX_CUR_RX_BC]) && $stable(bank_q[DSPT_IDX_CUR_RX_ST]))
    else $error("soft reset disturbed current receive copy");

endmodule

//--- dv/tb.sv
/*
 * Self-checking bench for the descriptor shadow and poll timer bank.
 * Assumes dspt_pkg and dspt_bank compiled first; drives Wishbone and loads itself.
 */
`timescale 1ns/1ps
module tb;
  import dspt_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, soft_reset_i = 0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, wb_err_o, tx_poll_o, rx_poll_o, running_o, er;
  dspt_desc_s crx = '0, ctx = '0, nrx = '0;
  int fails = 0, num_checks = 0;
  int model[10];
  bit stop_m = 1, susp_m = 0;
  int tq[$], rq[$];
  logic [31:0] w0, w1, w2;
  dspt_bank i_dspt_bank (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
    .cur_rx_desc_i(crx), .cur_tx_desc_i(ctx), .nxt_rx_desc_i(nrx),
    .soft_reset_i(soft_reset_i), .tx_poll_o(tx_poll_o), .rx_poll_o(rx_poll_o),
    .running_o(running_o));
  always #50 clk_i = ~clk_i;

  task automatic print_verdict();
    if (fails == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask

  // Classic single cycle; no latency assumed, bounded wait only
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1;
    wb_stb_i <= 1;
    wb_we_i <= w;
    wb_sel_i <= 4'hF;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
    if (n >= 20) begin
      fails++;
      print_verdict();
    end
    rd = wb_dat_o;
    er = wb_err_o;
    wb_cyc_i <= 0;
    wb_stb_i <= 0;
    wb_we_i <= 0;
  endtask

  function automatic int fmask(input int i);
    return (i == 0 || i == 2 || i == 4) ? 32'h0FFF : 32'hFFFF;
  endfunction

  task automatic wreg(input int i, input logic [31:0] d);
    bus(1, 6'(i * 4), d & 32'(fmask(i)));
    if (stop_m || susp_m) model[i] = d & fmask(i);
  endtask

  task automatic rchk(input int i);
    bus(0, 6'(i * 4), 32'h0);
    chk_word(rd, (stop_m || susp_m) ? 32'(model[i]) : 32'h0);
  endtask

  task automatic ctrl(input logic [3:0] v);
    bus(1, {DSPT_IDX_CTRL, 2'b00}, {28'h0, v});
    if (v[2]) stop_m = 1;
    else if (v[1] || v[0]) stop_m = 0;
    susp_m = v[3];
  endtask

  // Init only, wait for completion, then stop before any interval write
  task automatic do_init();
    ctrl(4'h1);
    for (int n = 0; n < 50; n++) begin
      bus(0, {DSPT_IDX_STATUS, 2'b00}, 32'h0);
      if (rd[DSPT_STAT_IDONE] === 1'b1) break;
    end
    chk_bit(rd[DSPT_STAT_IDONE], 1);
    ctrl(4'h4);
  endtask

  initial begin
    void'($urandom(32'h6d3a));
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    do_init();
    for (int i = 6; i < 10; i++) model[i] = 0;
    for (int i = 6; i < 10; i++) rchk(i);
    // Random fields; reserved bits go out as zero, as software must
    for (int i = 0; i < 10; i++) wreg(i, $urandom());
    for (int i = 0; i < 10; i++) rchk(i);
    w0 = $urandom();
    w1 = $urandom();
    w2 = $urandom();
    @(posedge clk_i);
    crx <= '{1'b1, w0};
    ctx <= '{1'b1, w1};
    nrx <= '{1'b1, w2};
    @(posedge clk_i);
    crx.load <= 0;
    ctx.load <= 0;
    nrx.load <= 0;
    model[0] = w0[11:0];
    model[1] = w0[31:16];
    model[2] = w1[11:0];
    model[3] = w1[31:16];
    model[4] = w2[11:0];
    model[5] = w2[31:16];
    rchk(0);
    rchk(1);
    rchk(2);
    rchk(3);
    rchk(4);
    rchk(5);
    ctrl(4'h2);
    chk_bit(running_o, 1);
    wreg(1, $urandom());
    rchk(1);
    wreg(7, $urandom());
    rchk(7);
    ctrl(4'hA);
    chk_bit(running_o, 0);
    wreg(3, $urandom());
    rchk(3);
    ctrl(4'h4);
    for (int i = 0; i < 6; i++) rchk(i);
    @(posedge clk_i);
    soft_reset_i <= 1;
    @(posedge clk_i);
    soft_reset_i <= 0;
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    stop_m = 1;
    susp_m = 0;
    for (int i = 0; i < 6; i++) rchk(i);
    rchk(7);
    do_init();
    // Low nibble of the interval is set but must not change the period
    wreg(6, 32'hFFC0);
    wreg(7, 32'hFFC5);
    wreg(8, 32'hFFF0);
    wreg(9, 32'h0000);
    ctrl(4'h2);
    for (int c = 0; c < 70000 && rq.size() < 2; c++) begin
      @(posedge clk_i);
      if (tx_poll_o === 1'b1) tq.push_back(c);
      if (rx_poll_o === 1'b1) rq.push_back(c);
    end
    chk_word(rq.size(), 2);
    if (rq.size() == 2) chk_word(rq[1] - rq[0], 65536);
    chk_bit(tq.size() > 100, 1);
    for (int i = 1; i < tq.size(); i++) chk_word(tq[i] - tq[i-1], 64);
    ctrl(4'h4);
    bus(0, 6'h30, 32'h0);
    chk_bit(er, 1);
    bus(1, 6'h05, 32'h0);
    chk_bit(er, 1);
    print_verdict();
  end
endmodule

//--- include/dspt_pkg.sv
/*
 * Package for the descriptor shadow and poll timer bank: register indices,
 * field layouts, control bit positions and timing constants.
 * Assumes a 32-bit classic Wishbone slave port, one aligned word per register.
 */
package dspt_pkg;

  // Register indices; byte address is four times the index
  localparam logic [3:0] DSPT_IDX_CUR_RX_BC = 4'h0;
  localparam logic [3:0] DSPT_IDX_CUR_RX_ST = 4'h1;
  localparam logic [3:0] DSPT_IDX_CUR_TX_BC = 4'h2;
  localparam logic [3:0] DSPT_IDX_CUR_TX_ST = 4'h3;
  localparam logic [3:0] DSPT_IDX_NXT_RX_BC = 4'h4;
  localparam logic [3:0] DSPT_IDX_NXT_RX_ST = 4'h5;
  localparam logic [3:0] DSPT_IDX_TX_POLL = 4'h6;
  localparam logic [3:0] DSPT_IDX_TX_PINT = 4'h7;
  localparam logic [3:0] DSPT_IDX_RX_POLL = 4'h8;
  localparam logic [3:0] DSPT_IDX_RX_PINT = 4'h9;
  localparam logic [3:0] DSPT_IDX_CTRL = 4'hA;
  localparam logic [3:0] DSPT_IDX_STATUS = 4'hB;
  localparam int DSPT_NUM_BANK = 10;

  // Field layouts
  localparam logic [15:0] DSPT_BC_MASK = 16'h0FFF;
  localparam logic [15:0] DSPT_FULL_MASK = 16'hFFFF;
  localparam logic [15:0] DSPT_PINT_MASK = 16'hFFF0;
  localparam logic [15:0] DSPT_CNT_WRAP = 16'hFFFF;
  localparam logic [15:0] DSPT_PINT_INIT = 16'h0000;
  localparam int DSPT_BC_MSB = 11;
  localparam int DSPT_ST_LSB = 16;

  // Control register bits
  localparam int DSPT_CTRL_INIT = 0;
  localparam int DSPT_CTRL_START = 1;
  localparam int DSPT_CTRL_STOP = 2;
  localparam int DSPT_CTRL_SUSPEND = 3;

  // Status register bits
  localparam int DSPT_STAT_IDONE = 0;
  localparam int DSPT_STAT_RUN = 1;
  localparam int DSPT_STAT_IBUSY = 2;

  // Reset values of control state
  localparam logic DSPT_STOP_RST = 1'b1;
  localparam logic DSPT_RUN_RST = 1'b0;

  // Length of the internal initialization routine, in clocks
  localparam int DSPT_INIT_CYCLES = 4;

  // Descriptor word 1 as captured by the fetch logic
  typedef struct packed {
    logic load;
    logic [31:0] word1;
  } dspt_desc_s;

  typedef enum {
    DSPT_IDLE,
    DSPT_INIT,
    DSPT_DONE
  } dspt_init_e;

endpackage
